// *** src/circ_top.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
// Function
// - one read/write control register holds all enables and flags except comparator.
// - the control register answers at two mirrored addresses, same storage.
// - flags set on their condition regardless of own enable and global enable.
// - global interrupt enable sits at bit 7.
// - bit 5 enables the timer overflow interrupt when one.
// - bit 4 enables the external pin interrupt when one.
// - bit 3 enables the port change interrupt when one.
// - bit 2 set on timer overflow, held until software clears it.
// - bit 1 set on external pin event, held until software writes zero.
// - bit 0 set when any upper port pin changes, held until cleared.
// - reset clears bits 7 to 1; bit 0 is loaded from PORT_FLG_RESET, which is zero.
module circ_top
  import circ_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0]    s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]  s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // event sources
  input  wire logic                 main_timer_overflow,
  input  wire logic                 periph_irq_req,
  input  wire logic                 ext_irq_pin,
  input  wire logic [PORT_PINS-1:0] port_pins,
  // request to the processor core
  output logic                      core_irq
);

  // register decode shared by the read and write paths
  function automatic circ_sel_e circ_decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      circ_decode = SEL_NONE;
    end else if (idx == IDX_CTRL_LOW) begin
      circ_decode = SEL_CTRL;
    end else if (idx == IDX_CTRL_HIGH) begin
      circ_decode = SEL_CTRL;
    end else if (idx == IDX_STATUS) begin
      circ_decode = SEL_STATUS;
    end else if (idx == IDX_CONFIG) begin
      circ_decode = SEL_CONFIG;
    end else begin
      circ_decode = SEL_NONE;
    end
  endfunction : circ_decode

  // byte-lane merge of the low byte only; upper lanes hold no storage
  function automatic logic [CTRL_W-1:0] circ_merge(
    input logic [CTRL_W-1:0]   old_val,
    input logic [DATA_W-1:0]   wdata,
    input logic [DATA_W/8-1:0] wstrb
  );
    circ_merge = wstrb[0] ? wdata[CTRL_W-1:0] : old_val;
  endfunction : circ_merge

  // all block state
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic              ext_rise;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              irq;
  } circ_state_s;

  circ_state_s st_q;
  circ_state_s st_d;

  // synchronised pins
  logic                 ext_level;
  logic                 ext_change;
  logic [PORT_PINS-1:0] port_level;
  logic [PORT_PINS-1:0] port_change;

  // combinational helpers
  logic                 ext_event;
  logic                 port_event;
  logic                 timer_event;
  logic                 do_write;
  logic                 do_read;
  circ_sel_e            wsel;
  circ_sel_e            rsel;
  logic [CTRL_W-1:0]    ctrl_wr;
  logic [CTRL_W-1:0]    ctrl_next;
  logic [DATA_W-1:0]    rd_word;
  logic                 irq_next;

  // external interrupt pin through the three-stage synchroniser
  circ_pin_sync #(
    .W (1)
  ) u_ext_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (ext_irq_pin),
    .level_q  (ext_level),
    .change_q (ext_change)
  );

  // upper port pins through the three-stage synchroniser
  circ_pin_sync #(
    .W (PORT_PINS)
  ) u_port_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (port_pins),
    .level_q  (port_level),
    .change_q (port_change)
  );

  // source events; edge polarity of the external pin is software selected
  always_comb begin
    timer_event = main_timer_overflow;
    ext_event   = ext_change & (ext_level == st_q.ext_rise);
    port_event  = |port_change;
  end

  // write handshake: address and data taken in either order, response after both
  always_comb begin
    do_write = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
    wsel     = circ_decode(st_q.aw_addr);
    ctrl_wr  = circ_merge(st_q.ctrl, st_q.w_data, st_q.w_strb);
  end

  // read handshake: one read under way, answer registered
  always_comb begin
    do_read = s_axi_arvalid & st_q.arready;
    rsel    = circ_decode(s_axi_araddr);
  end

  // next control register: software write first, then hardware sets on top
  always_comb begin
    ctrl_next = st_q.ctrl;
    if (do_write && wsel == SEL_CTRL) begin
      ctrl_next = ctrl_wr;
    end
    // set wins over a clearing write in the same cycle
    if (timer_event) begin
      ctrl_next[BIT_TIMER_FLG] = 1'b1;
    end
    if (ext_event) begin
      ctrl_next[BIT_EXT_FLG] = 1'b1;
    end
    if (port_event) begin
      ctrl_next[BIT_PORT_FLG] = 1'b1;
    end
  end

  // interrupt request from the registered control bits and the unregistered peripheral request input
  always_comb begin
    irq_next = st_q.ctrl[BIT_GLOBAL_EN] & (
                 (st_q.ctrl[BIT_TIMER_EN] & st_q.ctrl[BIT_TIMER_FLG]) |
                 (st_q.ctrl[BIT_EXT_EN]   & st_q.ctrl[BIT_EXT_FLG])   |
                 (st_q.ctrl[BIT_PORT_EN]  & st_q.ctrl[BIT_PORT_FLG])  |
                 (st_q.ctrl[BIT_PERIPH_EN] & periph_irq_req));
  end

  // read data mux; unused bits read as zero
  always_comb begin
    rd_word = '0;
    if (rsel == SEL_CTRL) begin
      rd_word[CTRL_W-1:0] = st_q.ctrl;
    end else if (rsel == SEL_STATUS) begin
      rd_word[ST_IRQ]                            = st_q.irq;
      rd_word[ST_EXT_LVL]                        = ext_level;
      rd_word[ST_PORT_LSB+PORT_PINS-1:ST_PORT_LSB] = port_level;
    end else if (rsel == SEL_CONFIG) begin
      rd_word[CFG_EXT_RISE] = st_q.ext_rise;
    end
  end

  // next-state assembly
  always_comb begin
    st_d      = st_q;
    st_d.ctrl = ctrl_next;
    st_d.irq  = irq_next;

    // capture write address
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
      st_d.awready = 1'b0;
    end

    // capture write data
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
      st_d.wready = 1'b0;
    end

    // perform the write and raise the response
    if (do_write) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (wsel == SEL_CONFIG && st_q.w_strb[0]) begin
        st_d.ext_rise = st_q.w_data[CFG_EXT_RISE];
      end
    end

    // response taken, reopen both write channels
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid  = 1'b0;
      st_d.bresp   = RESP_OKAY;
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
    end

    // read address taken, data registered next edge
    if (do_read) begin
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rdata   = rd_word;
      st_d.rresp   = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end

    // read data taken, reopen read address
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid  = 1'b0;
      st_d.rdata   = '0;
      st_d.rresp   = RESP_OKAY;
      st_d.arready = 1'b1;
    end
  end

  // state register; reset clears enables and upper flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q                     <= '0;
      st_q.ctrl                <= CTRL_RESET;
      st_q.ctrl[BIT_PORT_FLG]  <= PORT_FLG_RESET;
      st_q.ext_rise            <= EXT_RISE_RESET;
      st_q.awready             <= 1'b1;
      st_q.wready              <= 1'b1;
      st_q.arready             <= 1'b1;
      st_q.bresp               <= RESP_OKAY;
      st_q.rresp               <= RESP_OKAY;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign core_irq      = st_q.irq;

endmodule : circ_top

// *** inc/circ_pkg.sv ***
// shared constants for the core interrupt control register block
package circ_pkg;

  // bus geometry
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned CTRL_W      = 8;
  localparam int unsigned PORT_PINS   = 4;

  // printed register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL_LOW  = 10'h00B;
  localparam logic [9:0] IDX_CTRL_HIGH = 10'h08B;
  // block-local registers
  localparam logic [9:0] IDX_STATUS    = 10'h000;
  localparam logic [9:0] IDX_CONFIG    = 10'h001;

  // interrupt_control field positions
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_PERIPH_EN = 6;
  localparam int unsigned BIT_TIMER_EN  = 5;
  localparam int unsigned BIT_EXT_EN    = 4;
  localparam int unsigned BIT_PORT_EN   = 3;
  localparam int unsigned BIT_TIMER_FLG = 2;
  localparam int unsigned BIT_EXT_FLG   = 1;
  localparam int unsigned BIT_PORT_FLG  = 0;

  // status register field positions
  localparam int unsigned ST_IRQ        = 0;
  localparam int unsigned ST_EXT_LVL    = 1;
  localparam int unsigned ST_PORT_LSB   = 4;

  // config register field positions
  localparam int unsigned CFG_EXT_RISE  = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic       PORT_FLG_RESET = 1'b0;
  localparam logic       EXT_RISE_RESET = 1'b1;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register selects, one-hot
  typedef enum logic [3:0] {
    SEL_NONE   = 4'h1,
    SEL_CTRL   = 4'h2,
    SEL_STATUS = 4'h4,
    SEL_CONFIG = 4'h8
  } circ_sel_e;

endpackage : circ_pkg

// *** src/circ_pin_sync.sv ***
`timescale 1ns/10ps
// three-stage pin synchroniser; a change counts once stages two and three agree
module circ_pin_sync
  import circ_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_q,
  output logic      [W-1:0] change_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
    logic [W-1:0] change;
    logic [1:0]   fill;
    logic         primed;
  } circ_sync_s;

  circ_sync_s st_q;
  circ_sync_s st_d;

  // shift chain, filtered level and change pulse
  always_comb begin
    st_d        = st_q;
    st_d.s1     = pin_in;
    st_d.s2     = st_q.s1;
    st_d.s3     = st_q.s2;
    st_d.change = '0;
    // arm only once stages two and three hold real pin samples, not reset zeros
    if (st_q.fill != 2'h3) begin
      st_d.fill = st_q.fill + 2'h1;
    end else begin
      st_d.primed = 1'b1;
    end
    if (st_q.s2 == st_q.s3) begin
      st_d.level  = st_q.s3;
      // a pin already high at reset loads silently, no spurious event
      if (st_q.primed) begin
        st_d.change = st_q.s3 ^ st_q.level;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_q  = st_q.level;
  assign change_q = st_q.change;

endmodule : circ_pin_sync

// *** sim/circ_properties.sv ***
`timescale 1ns/10ps
// bus and reset checks seen at the top ports
module circ_checker
  import circ_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              core_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // response timing and holding
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
  // eight-bit storage, upper bits read zero
  property p_r_width;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_r_width: assert property (p_r_width) else $error("upper read bits set");
  property p_r_err;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_r_err: assert property (p_r_err) else $error("error read not zero");
  // outputs idle at first edge after reset
  property p_rst;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !core_irq;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");

  // main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(core_irq));
endmodule : circ_checker

bind circ_top circ_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .core_irq);

// *** sim/circ_src_model.sv ***
`timescale 1ns/10ps
// event sources beside the core: timer, edge pin, port pins, peripheral
module circ_src_model (
  input  wire logic       aclk,
  input  wire logic       tmr_req,
  input  wire logic       ext_lvl,
  input  wire logic [3:0] port_lvl,
  input  wire logic       per_lvl,
  output logic            main_timer_overflow,
  output logic            periph_irq_req,
  output logic            ext_irq_pin,
  output logic      [3:0] port_pins
);
  // one overflow pulse per request, pins follow their levels
  always_ff @(posedge aclk) begin
    main_timer_overflow <= tmr_req;
    ext_irq_pin         <= ext_lvl;
    port_pins           <= port_lvl;
    periph_irq_req      <= per_lvl;
  end
endmodule : circ_src_model

// *** sim/core_interrupt_control_register_tb.sv ***
`timescale 1ns/10ps
module core_interrupt_control_register_tb
  import circ_pkg::*;
;
  localparam logic [ADDR_W-1:0] A_LO  = {IDX_CTRL_LOW, 2'b00};
  localparam logic [ADDR_W-1:0] A_HI  = {IDX_CTRL_HIGH, 2'b00};
  localparam logic [ADDR_W-1:0] A_BAD = 12'h0fc;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, core_irq, tmr_req, ext_lvl, per_lvl;
  logic              main_timer_overflow, periph_irq_req, ext_irq_pin;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [3:0]        s_axi_wstrb, port_lvl, port_pins;
  int                n_mismatch, tests_run;

  circ_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .main_timer_overflow, .periph_irq_req, .ext_irq_pin, .port_pins, .core_irq);
  circ_src_model u_src (.aclk, .tmr_req, .ext_lvl, .port_lvl, .per_lvl,
    .main_timer_overflow, .periph_irq_req, .ext_irq_pin, .port_pins);

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // write: address and data offered together, each released once taken
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : axw

  // read: result left in rd
  task automatic axr(input logic [ADDR_W-1:0] a, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : axr

  // pulse the timer or toggle a pin, then let the pin path settle
  task automatic fire(input int i);
    case (i)
      0: tmr_req <= 1'b1;
      1: ext_lvl <= ~ext_lvl;
      default: port_lvl <= port_lvl ^ 4'h8;
    endcase
    @(posedge aclk);
    tmr_req <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : fire

  task automatic irq_is(input logic e);
    repeat (2) @(posedge aclk);
    chk({31'h0, core_irq}, {31'h0, e});
  endtask : irq_is

  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {tmr_req, ext_lvl, per_lvl, port_lvl, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    s_axi_wstrb <= 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(A_LO, RESP_OKAY);
    chk(rd & 32'h0000_00fe, 32'h0000_0000);
    axw(A_LO, 8'hf8, RESP_OKAY);
    axr(A_HI, RESP_OKAY);
    chk(rd, 32'h0000_00f8);
    axw(A_BAD, 8'hff, RESP_SLVERR);
    axr(A_BAD, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    axw(A_HI, 8'h00, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      fire(i);
      axr(A_LO, RESP_OKAY);
      chk(rd, 32'h0000_0004 >> i);
      axw(A_LO, 8'h24 >> i, RESP_OKAY);
      irq_is(1'b0);
      axw(A_LO, 8'h80 | (8'h24 >> i), RESP_OKAY);
      irq_is(1'b1);
      axw(A_LO, 8'h80 | (8'h20 >> i), RESP_OKAY);
      irq_is(1'b0);
      axw(A_LO, 8'h00, RESP_OKAY);
    end
    // status: ext pin high, top port pin high, no request
    axr(12'h000, RESP_OKAY);
    chk(rd, 32'h0000_0082);
    // falling-edge select, then drop the external pin
    axw(12'h004, 8'h00, RESP_OKAY);
    fire(1);
    axr(A_LO, RESP_OKAY);
    chk(rd, 32'h0000_0002);
    axw(A_LO, 8'h00, RESP_OKAY);
    per_lvl <= 1'b1;
    axw(A_LO, 8'h80, RESP_OKAY);
    irq_is(1'b0);
    axw(A_LO, 8'hc0, RESP_OKAY);
    irq_is(1'b1);
    print_verdict;
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    print_verdict;
  end
endmodule : core_interrupt_control_register_tb
